// ### logic/opf_port.sv
// multi-function output port with axi4-lite register slave
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "opf_consts.svh"
module opf_port (
	input wire logic clk,
	input wire logic rst,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire opf_pkg::opf_summary_type summaryIn,
	input wire logic [2:0] portLineIn,
	output opf_pkg::opf_lines_type portLines,
	output logic unitOutputEnable,
	output logic measureTrigger,
	output logic irq
);
	import opf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		opf_mode_type mode;
		opf_beh_type beh;
		logic fie;
		opf_src_type src;
		logic [2:0] digOut;
		logic [2:0] lineSeen;
		logic disLatched;
		logic [2:0] irqStat;
		logic [2:0] irqEn;
		logic awHeld;
		logic [`OPF_ADDR_W-1:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic awRdy;
		logic wRdy;
		logic arRdy;
		opf_lines_type lines;
		logic unitOn;
		logic trig;
		logic irqOut;
	} opf_state_type;

	opf_state_type state_reg;
	opf_state_type state_next;

	logic disableRequestInput;
	logic faultSel;
	logic trigEdge;
	logic disAsserted;
	logic doWrite;
	logic doRead;
	logic [2:0] irqSet;
	logic [2:0] irqClr;
	logic [31:0] ctrlWord;
	logic rearm;

	////////////////////////////////////////////////////////////////////////
	// line 0 is the disable input in disable/fault mode and the trigger input in trigger mode
	assign disableRequestInput = portLineIn[0];
	assign disAsserted = (state_reg.mode == OPF_MODE_DISFLT) &&
		(state_reg.beh != OPF_BEH_OFF) && !disableRequestInput;
	assign trigEdge = (state_reg.mode == OPF_MODE_TRIGGER) &&
		state_reg.lineSeen[0] && !portLineIn[0];

	always_comb begin
		unique case (state_reg.src)
			OPF_SRC_RQS: faultSel = summaryIn.rqs;
			OPF_SRC_ESB: faultSel = summaryIn.esb;
			OPF_SRC_OPERATION_SUMMARY_SOURCE: faultSel = summaryIn.operation_summary_source;
			OPF_SRC_QUESTIONABLE_SUMMARY_SOURCE: faultSel = summaryIn.questionable_summary_source;
		endcase
	end

	assign ctrlWord = {25'h0000000, state_reg.src, state_reg.fie,
		state_reg.beh, state_reg.mode};

	assign doWrite = state_reg.awHeld && state_reg.wHeld && !state_reg.bValid;
	assign doRead = s_axi_arvalid && !state_reg.rValid;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		irqSet = 3'h0;
		irqClr = 3'h0;
		rearm = 1'b0;
		// axi write address and data, taken in either order
		if (s_axi_awvalid && !state_reg.awHeld) begin
			state_next.awHeld = 1'b1;
			state_next.awAddr = s_axi_awaddr[`OPF_ADDR_W-1:0];
		end
		if (s_axi_wvalid && !state_reg.wHeld) begin
			state_next.wHeld = 1'b1;
			state_next.wData = s_axi_wdata;
			state_next.wStrb = s_axi_wstrb;
		end
		if (doWrite) begin
			state_next.awHeld = 1'b0;
			state_next.wHeld = 1'b0;
			state_next.bValid = 1'b1;
			state_next.bResp = `OPF_RESP_OKAY;
			unique case (state_reg.awAddr)
				`OPF_OFS_CTRL: begin
					if (state_reg.wStrb[0]) begin
						state_next.mode = opf_mode_type'(
							state_reg.wData[`OPF_CTRL_MODE_LSB +: 2]);
						state_next.beh = opf_beh_type'(
							state_reg.wData[`OPF_CTRL_BEH_LSB +: 2]);
						state_next.fie = state_reg.wData[`OPF_CTRL_FIE_BIT];
						state_next.src = opf_src_type'(
							state_reg.wData[`OPF_CTRL_SRC_LSB +: 2]);
					end
					if (state_reg.wStrb[1]) begin
						rearm = state_reg.wData[`OPF_CTRL_REARM_BIT];
					end
				end
				`OPF_OFS_DIGOUT: begin
					if (state_reg.wStrb[0]) begin
						state_next.digOut = state_reg.wData[2:0];
					end
				end
				`OPF_OFS_IRQ_EN: begin
					if (state_reg.wStrb[0]) begin
						state_next.irqEn = state_reg.wData[2:0];
					end
				end
				`OPF_OFS_IRQ_CLR: begin
					if (state_reg.wStrb[0]) begin
						irqClr = state_reg.wData[2:0];
					end
				end
				`OPF_OFS_DIGIN, `OPF_OFS_STATUS, `OPF_OFS_IRQ_STAT: begin
				end
				default: state_next.bResp = `OPF_RESP_SLVERR;
			endcase
		end
		if (state_reg.bValid && s_axi_bready) begin
			state_next.bValid = 1'b0;
		end
		// axi read
		if (doRead) begin
			state_next.rValid = 1'b1;
			state_next.rResp = `OPF_RESP_OKAY;
			unique case (s_axi_araddr[`OPF_ADDR_W-1:0])
				`OPF_OFS_CTRL: state_next.rData = ctrlWord;
				`OPF_OFS_DIGOUT: state_next.rData = {29'h0, state_reg.digOut};
				`OPF_OFS_DIGIN: state_next.rData = {29'h0, state_reg.lineSeen};
				`OPF_OFS_STATUS: state_next.rData = {29'h0, faultSel,
					state_reg.disLatched, state_reg.unitOn};
				`OPF_OFS_IRQ_STAT: state_next.rData = {29'h0, state_reg.irqStat};
				`OPF_OFS_IRQ_EN: state_next.rData = {29'h0, state_reg.irqEn};
				`OPF_OFS_IRQ_CLR: state_next.rData = 32'h00000000;
				default: begin
					state_next.rData = 32'h00000000;
					state_next.rResp = `OPF_RESP_SLVERR;
				end
			endcase
		end
		if (state_reg.rValid && s_axi_rready) begin
			state_next.rValid = 1'b0;
		end
		// port input sampling
		state_next.lineSeen = portLineIn;
		// disable handling
		if (state_reg.beh != OPF_BEH_LATCH || state_reg.mode != OPF_MODE_DISFLT
			|| rearm) begin
			state_next.disLatched = 1'b0;
		end
		if (disAsserted && state_reg.beh == OPF_BEH_LATCH) begin
			state_next.disLatched = 1'b1;
		end
		state_next.unitOn = !disAsserted && !state_next.disLatched;
		// line drivers
		state_next.lines = '0;
		unique case (state_reg.mode)
			OPF_MODE_DISFLT: begin
				// line 1 open-collector fault, pulled low on fault
				state_next.lines.oe[1] = state_reg.fie && faultSel;
				state_next.lines.out[1] = 1'b0;
			end
			OPF_MODE_PARALLEL: begin
				state_next.lines.out = state_reg.digOut;
				state_next.lines.oe = 3'h7;
			end
			OPF_MODE_TRIGGER: begin
			end
			default: begin
			end
		endcase
		state_next.trig = trigEdge;
		// interrupt events, set wins over clear
		irqSet[`OPF_IRQ_DISABLE] = disAsserted && state_reg.unitOn;
		irqSet[`OPF_IRQ_TRIG] = trigEdge;
		irqSet[`OPF_IRQ_FAULT] = (state_reg.mode == OPF_MODE_DISFLT) &&
			state_reg.fie && faultSel;
		state_next.irqStat = (state_reg.irqStat & ~irqClr) | irqSet;
		state_next.irqOut = |(state_next.irqStat & state_next.irqEn);
		// ready flags registered so bus outputs leave flip-flops directly
		state_next.awRdy = !state_next.awHeld;
		state_next.wRdy = !state_next.wHeld;
		state_next.arRdy = !state_next.rValid;
		if (rst) begin
			state_next = '0;
			state_next.mode = OPF_MODE_DISFLT;
			state_next.beh = OPF_BEH_OFF;
			state_next.src = OPF_SRC_RQS;
			state_next.digOut = `OPF_DIG_RESET;
			state_next.lineSeen = 3'h7;
			state_next.unitOn = 1'b1;
			state_next.awRdy = 1'b1;
			state_next.wRdy = 1'b1;
			state_next.arRdy = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////////////
	assign s_axi_awready = state_reg.awRdy;
	assign s_axi_wready = state_reg.wRdy;
	assign s_axi_bvalid = state_reg.bValid;
	assign s_axi_bresp = state_reg.bResp;
	assign s_axi_arready = state_reg.arRdy;
	assign s_axi_rvalid = state_reg.rValid;
	assign s_axi_rdata = state_reg.rData;
	assign s_axi_rresp = state_reg.rResp;
	assign portLines = state_reg.lines;
	assign unitOutputEnable = state_reg.unitOn;
	assign measureTrigger = state_reg.trig;
	assign irq = state_reg.irqOut;
endmodule : opf_port

// ### inc/opf_consts.svh
// register offsets, field positions and reset values of the port block
`ifndef OPF_CONSTS_SVH
`define OPF_CONSTS_SVH
`define OPF_ADDR_W 6
`define OPF_OFS_CTRL 6'h00
`define OPF_OFS_DIGOUT 6'h04
`define OPF_OFS_DIGIN 6'h08
`define OPF_OFS_STATUS 6'h0C
`define OPF_OFS_IRQ_STAT 6'h10
`define OPF_OFS_IRQ_EN 6'h14
`define OPF_OFS_IRQ_CLR 6'h18
`define OPF_CTRL_MODE_LSB 0
`define OPF_CTRL_BEH_LSB 2
`define OPF_CTRL_FIE_BIT 4
`define OPF_CTRL_SRC_LSB 5
`define OPF_CTRL_REARM_BIT 8
`define OPF_CTRL_RESET 32'h00000000
`define OPF_DIG_RESET 3'h0
`define OPF_IRQ_W 3
`define OPF_IRQ_DISABLE 0
`define OPF_IRQ_TRIG 1
`define OPF_IRQ_FAULT 2
`define OPF_RESP_OKAY 2'h0
`define OPF_RESP_SLVERR 2'h2
`endif

// ### inc/opf_pkg.sv
// types of the port block
package opf_pkg;
	typedef enum logic [1:0] {
		OPF_MODE_DISFLT,
		OPF_MODE_PARALLEL,
		OPF_MODE_TRIGGER,
		OPF_MODE_SPARE
	} opf_mode_type;
	typedef enum logic [1:0] {
		OPF_BEH_OFF,
		OPF_BEH_LIVE,
		OPF_BEH_LATCH,
		OPF_BEH_SPARE
	} opf_beh_type;
	typedef enum logic [1:0] {
		OPF_SRC_RQS,
		OPF_SRC_ESB,
		OPF_SRC_OPERATION_SUMMARY_SOURCE,
		OPF_SRC_QUESTIONABLE_SUMMARY_SOURCE
	} opf_src_type;
	typedef struct packed {
		logic rqs;
		logic esb;
		logic operation_summary_source;
		logic questionable_summary_source;
	} opf_summary_type;
	typedef struct packed {
		logic [2:0] out;
		logic [2:0] oe;
	} opf_lines_type;
	typedef enum logic [1:0] {
		OPF_BUS_IDLE,
		OPF_BUS_RESP
	} opf_bus_type;
endpackage : opf_pkg

// ### bench/opf_port_asserts.sv
// pin assertions for the port block
`timescale 1ns/1ns
module opf_port_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire opf_pkg::opf_lines_type portLines,
	input wire logic [2:0] portLineIn,
	input wire logic unitOutputEnable,
	input wire logic measureTrigger,
	input wire logic irq
);
	import opf_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_OE_SET: assert property (portLines.oe inside {3'h0, 3'h2, 3'h7})
		else $error("bad oe");
	AST_FLT_LOW: assert property (portLines.oe == 3'h2 |-> !portLines.out[1])
		else $error("fault high");
	AST_TRIG_ONE: assert property (measureTrigger |=> !measureTrigger)
		else $error("long trigger");
	AST_TRIG_QUIET: assert property (portLines.oe == 3'h7 |-> !measureTrigger)
		else $error("stray trigger");
	AST_DIS_CAUSE: assert property ($fell(unitOutputEnable) |->
		!$past(portLineIn[0]) || !$past(portLineIn[0], 2)) else $error("stray off");
	AST_AW_REFUSE: assert property (s_axi_awvalid && s_axi_awready |=>
		!s_axi_awready) else $error("aw taken twice");
	AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no bvalid");
	AST_IRQ_FALL: assert property ($fell(irq) |-> s_axi_bvalid)
		else $error("irq drop");
	cover property (measureTrigger);
	cover property ($fell(unitOutputEnable));
	cover property (portLines.oe == 3'h2);
endmodule : opf_port_asserts
bind opf_port opf_port_asserts u_chk (.clk, .rst, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .portLines,
	.portLineIn, .unitOutputEnable, .measureTrigger, .irq);

// ### bench/opf_far_end.sv
// far-end equipment on the port lines
`timescale 1ns/1ns
module opf_far_end (
	input wire opf_pkg::opf_lines_type portLines,
	input wire logic [2:0] extLevel,
	output logic [2:0] portLineIn
);
	import opf_pkg::*;
	// driven lines win, released lines show the equipment level
	assign portLineIn = portLines.oe & portLines.out
		| ~portLines.oe & extLevel;
endmodule : opf_far_end

// ### bench/tb.sv
// bench for the port block
`timescale 1ns/1ns
`include "opf_consts.svh"
module tb;
	import opf_pkg::*;
	logic clk = 1'h0, rst = 1'h1;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
	logic s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, unitOutputEnable;
	logic measureTrigger, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rdResp, wrResp, lvl;
	logic [31:0] s_axi_rdata, rdData;
	logic [2:0] portLineIn, extLevel = 3'h7;
	opf_summary_type summaryIn = '0;
	opf_lines_type portLines;
	int checks = 0, fail_count = 0, seed = 64468, trigs;
	opf_port u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .summaryIn, .portLineIn, .portLines, .unitOutputEnable,
		.measureTrigger, .irq);
	opf_far_end u_far (.portLines, .extLevel, .portLineIn);
	initial forever #25 clk = ~clk;
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wr(logic [5:0] a, logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= {26'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		wrResp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wr
	task automatic rd(logic [5:0] a);
		@(posedge clk);
		s_axi_araddr <= {26'h0, a};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rdData = s_axi_rdata;
		rdResp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : rd
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s exp %0h got %0h", n, e, g);
		end
	endtask : chk
	function automatic logic [2:0] fltOe(logic [2:0] s);
		return (!s[2] && summaryIn[3 - s[1:0]]) ? 3'h2 : 3'h0;
	endfunction : fltOe
	function automatic logic [1:0] disLvl(logic [1:0] b);
		return (b == 2'h2) ? 2'h0 : (b == 2'h0) ? 2'h3 : 2'h1;
	endfunction : disLvl
	task automatic report_and_stop();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	initial begin
		cyc(3000);
		fail_count++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		rd(`OPF_OFS_CTRL);
		chk("ctrl", `OPF_CTRL_RESET, rdData);
		rd(6'h3C);
		chk("resp", `OPF_RESP_SLVERR, rdResp);
		wr(6'h3C, 32'h0);
		chk("bresp", `OPF_RESP_SLVERR, wrResp);
		wr(`OPF_OFS_CTRL, 32'h3);
		cyc(3);
		chk("spare", 6'h00, portLines);
		wr(`OPF_OFS_CTRL, 32'h1);
		chk("okay", `OPF_RESP_OKAY, wrResp);
		for (int v = 0; v < 8; v++) begin
			wr(`OPF_OFS_DIGOUT, 32'(v));
			cyc(2);
			chk("lines", {v[2:0], 3'h7}, portLines);
			rd(`OPF_OFS_DIGIN);
			chk("digin", 32'(v), rdData);
		end
		for (int s = 0; s < 16; s++) begin
			summaryIn <= 4'($random(seed));
			wr(`OPF_OFS_CTRL, 32'({s[1:0], !s[2], 4'h0}));
			cyc(3);
			chk("fault", fltOe(s[2:0]), portLines.oe);
		end
		summaryIn <= '0;
		for (int b = 0; b < 4; b++) begin
			wr(`OPF_OFS_CTRL, 32'(b << 2));
			extLevel <= 3'h6;
			cyc(4);
			lvl[1] = unitOutputEnable;
			extLevel <= 3'h7;
			cyc(4);
			lvl[0] = unitOutputEnable;
			chk("disable", disLvl(b[1:0]), lvl);
			wr(`OPF_OFS_CTRL, 32'(b << 2) | 32'h100);
			cyc(3);
			chk("rearm", 1'h1, unitOutputEnable);
		end
		wr(`OPF_OFS_CTRL, 32'h2);
		wr(`OPF_OFS_IRQ_CLR, 32'h7);
		wr(`OPF_OFS_IRQ_EN, 32'h2);
		trigs = 0;
		extLevel <= 3'h6;
		repeat (6) begin
			@(posedge clk);
			trigs += int'(measureTrigger === 1'h1);
		end
		chk("trig", 32'h1, trigs);
		chk("irq", 1'h1, irq);
		rd(`OPF_OFS_IRQ_STAT);
		chk("stat", 32'h2, rdData);
		wr(`OPF_OFS_IRQ_EN, 32'h0);
		cyc(3);
		chk("mask", 1'h0, irq);
		wr(`OPF_OFS_IRQ_CLR, 32'h2);
		wr(`OPF_OFS_IRQ_EN, 32'h2);
		cyc(3);
		chk("clear", 1'h0, irq);
		report_and_stop();
	end
endmodule : tb
